// ---- logic/irq_output_config_holdoff.sv ----
/*
 * Interrupt output stage: combined request, hold-off interval timer and
 * configurable pin driver, with its one configuration register.
 * Assumes source flags and enables come from same-clock logic and that
 * the pin's pad resolves level from the output and output enable.
 */
`timescale 1ns/1ps
`include "irq_out_defs.svh"

module irq_output_config_holdoff
    import irq_out_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = `HOLDOFF_UNIT_CYCLES,
    parameter int unsigned NUM_SRC = 32,
    parameter int unsigned POWER_SRC = 17
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic [7:0] stat_addr,
    input wire logic stat_wr,
    input wire logic [NUM_SRC-1:0] source_set,
    input wire logic [NUM_SRC-1:0] source_enable,
    output logic [NUM_SRC-1:0] source_status_flags,
    output logic irq_out,
    output logic irq_oe
);

    initial
    begin
        if (NUM_SRC < 1 || NUM_SRC > 32 || POWER_SRC >= NUM_SRC)
            $error("source count or power event index out of range");
        if (UNIT_CYCLES < 1)
            $error("hold-off unit must be at least one cycle");
    end

    // ----------------------------------------------------------------
    // configuration fields
    // ----------------------------------------------------------------
    logic [7:0] holdoff_interval;
    logic pin_enable;
    logic pin_polarity_select;
    logic buffer_type;
    logic holdoff_active;
    logic [7:0] holdoff_count;
    logic unit_tick;
    logic combined_req;
    logic power_event_signal;
    logic held_req;
    logic pin_assert;
    holdoff_state_t state;
    logic cfg_wr;
    logic [NUM_SRC-1:0] ack;

    assign cfg_wr = reg_wr && (reg_addr == `IRQ_CFG_OFFSET);

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            holdoff_interval <= 8'h00;
            pin_enable <= 1'b0;
            pin_polarity_select <= 1'b0;
            buffer_type <= 1'b0;
        end
        else if (cfg_wr)
        begin
            holdoff_interval <=
                reg_wdata[`HOLDOFF_INTERVAL_HI:`HOLDOFF_INTERVAL_LO];
            pin_enable <= reg_wdata[`PIN_ENABLE_BIT];
            pin_polarity_select <= reg_wdata[`PIN_POLARITY_BIT];
            buffer_type <= reg_wdata[`BUFFER_TYPE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // source flags
    // ----------------------------------------------------------------
    // a set in the same cycle as its acknowledge wins
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++)
        begin : g_src
            assign ack[gi] = stat_wr && (stat_addr == `IRQ_STS_OFFSET) &&
                reg_wdata[gi];
            always_ff @(posedge mclk)
            begin
                if (!resetn)
                    source_status_flags[gi] <= 1'(`IRQ_SRC_RESET >> gi);
                else if (source_set[gi])
                    source_status_flags[gi] <= 1'b1;
                else if (ack[gi])
                    source_status_flags[gi] <= 1'b0;
            end
        end
    endgenerate

    // independent of pin enable and interval
    assign combined_req = |(source_status_flags & source_enable);
    assign power_event_signal = source_status_flags[POWER_SRC] &&
        source_enable[POWER_SRC];
    // enabled sources other than the power event, subject to hold-off
    assign held_req = |(source_status_flags & source_enable &
        ~(NUM_SRC'(1) << POWER_SRC));

    // ----------------------------------------------------------------
    // hold-off timer
    // ----------------------------------------------------------------
    // time base
    holdoff_prescaler #(.DIVIDE(UNIT_CYCLES)) u_prescaler
    (
        .mclk(mclk),
        .resetn(resetn),
        .unit_tick(unit_tick)
    );

    // interval starts when the pin drops after a delivered request
    logic pin_assert_q;
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            pin_assert_q <= 1'b0;
        else
            pin_assert_q <= pin_assert;
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            state <= HOLD_IDLE;
            holdoff_count <= 8'h00;
        end
        // zero interval cancels hold-off at once
        else if (cfg_wr &&
            reg_wdata[`HOLDOFF_INTERVAL_HI:`HOLDOFF_INTERVAL_LO] == 8'h00)
        begin
            state <= HOLD_IDLE;
            holdoff_count <= 8'h00;
        end
        // restart clears the count and opens a fresh interval
        else if (cfg_wr && reg_wdata[`HOLDOFF_RESTART_BIT])
        begin
            state <= HOLD_RUN;
            holdoff_count <= 8'h00;
        end
        else
        begin
            unique case (state)
                HOLD_IDLE:
                begin
                    // current interval used on each new deassertion
                    if (pin_assert_q && !pin_assert &&
                        holdoff_interval != 8'h00)
                    begin
                        state <= HOLD_RUN;
                        holdoff_count <= 8'h00;
                    end
                end
                HOLD_RUN:
                begin
                    // a power event dropping mid-interval restarts it, so
                    // a deassertion is never lost to a same-cycle expiry
                    if (pin_assert_q && !pin_assert)
                        holdoff_count <= 8'h00;
                    // expiry returns to idle so pin asserts next cycle
                    else if (unit_tick)
                    begin
                        if (holdoff_count + 8'h01 >= holdoff_interval)
                            state <= HOLD_IDLE;
                        holdoff_count <= holdoff_count + 8'h01;
                    end
                end
            endcase
        end
    end

    assign holdoff_active = (state == HOLD_RUN);

    // ----------------------------------------------------------------
    // pin driver
    // ----------------------------------------------------------------
    // power event passes during hold-off
    // pin enable gates the output and the pin drop that starts hold-off
    // status bits untouched by the gate
    assign pin_assert = pin_enable &&
        ((held_req && !holdoff_active) || power_event_signal);

    // open drain drives only while asserting
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            irq_out <= 1'b0;
            irq_oe <= 1'b0;
        end
        else if (!buffer_type)
        begin
            irq_out <= 1'b0;
            irq_oe <= pin_assert;
        end
        else
        begin
            irq_out <= pin_polarity_select ? pin_assert : !pin_assert;
            irq_oe <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // restart bit self-clears, so it always reads zero
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd && reg_addr == `IRQ_CFG_OFFSET)
        begin
            reg_rdata <= 32'h0000_0000;
            reg_rdata[`HOLDOFF_INTERVAL_HI:`HOLDOFF_INTERVAL_LO] <=
                holdoff_interval;
            reg_rdata[`HOLDOFF_ACTIVE_BIT] <= holdoff_active;
            reg_rdata[`COMBINED_REQ_BIT] <= combined_req;
            reg_rdata[`PIN_ENABLE_BIT] <= pin_enable;
            reg_rdata[`PIN_POLARITY_BIT] <= pin_polarity_select;
            reg_rdata[`BUFFER_TYPE_BIT] <= buffer_type;
        end
        else if (reg_rd)
            reg_rdata <= 32'h0000_0000;
    end

endmodule

// ---- include/irq_out_defs.svh ----
/*
 * Offsets, field positions, reset values and timing counts of the
 * interrupt output configuration register.
 * Assumes a 32-bit register port with byte addresses.
 */
`ifndef IRQ_OUT_DEFS_SVH
`define IRQ_OUT_DEFS_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define IRQ_CFG_OFFSET 8'h54
`define IRQ_STS_OFFSET 8'h58
`define IRQ_CFG_RESET 32'h0000_0000
`define IRQ_SRC_RESET 32'h0000_0000

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define HOLDOFF_INTERVAL_HI 31
`define HOLDOFF_INTERVAL_LO 24
`define HOLDOFF_RESTART_BIT 14
`define HOLDOFF_ACTIVE_BIT 13
`define COMBINED_REQ_BIT 12
`define PIN_ENABLE_BIT 8
`define PIN_POLARITY_BIT 4
`define BUFFER_TYPE_BIT 0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_FREQ_HZ 50000000
`define HOLDOFF_UNIT_NS 10000
`define CLK_PERIOD_NS 20
`define HOLDOFF_UNIT_CYCLES (`HOLDOFF_UNIT_NS / `CLK_PERIOD_NS)

`endif

// ---- include/irq_out_pkg.sv ----
/*
 * Types shared by the interrupt output stage.
 * Assumes the constants header is included by whoever needs numbers.
 */
package irq_out_pkg;

    // hold-off sequencer states
    typedef enum logic [1:0]
    {
        HOLD_IDLE,
        HOLD_RUN
    } holdoff_state_t;

endpackage

// ---- logic/holdoff_prescaler.sv ----
/*
 * Free-running divider that yields one tick per hold-off unit.
 * Assumes mclk at the rate given in the constants header.
 */
`timescale 1ns/1ps
`include "irq_out_defs.svh"

module holdoff_prescaler
#(
    parameter int unsigned DIVIDE = `HOLDOFF_UNIT_CYCLES
)
(
    input wire logic mclk,
    input wire logic resetn,
    output logic unit_tick
);

    localparam int W = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
    localparam logic [W-1:0] LAST = W'(DIVIDE - 1);

    logic [W-1:0] count;

    initial
    begin
        if (DIVIDE < 1)
            $error("divider must be at least one");
    end

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    // never restarted, so a tick may come early in the first unit
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            count <= '0;
        else if (count == LAST)
            count <= '0;
        else
            count <= count + W'(1);
    end

    // tick output registered
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            unit_tick <= 1'b0;
        else
            unit_tick <= (count == LAST);
    end

endmodule

// ---- bench/irq_host_input.sv ----
/* host interrupt input model for the pin of the output stage.
   assumes a pull-up on the wire and a host told the active level. */
`timescale 1ns/1ps
module irq_host_input
(
    input wire logic irq_out,
    input wire logic irq_oe,
    input wire logic active_high,
    output logic irq_seen
);
    logic pin;
    assign pin = irq_oe ? irq_out : 1'b1; // released wire floats high
    assign irq_seen = active_high ? pin : ~pin;
endmodule

// ---- bench/irq_out_checker_assertions.sv ----
/* assertions on the ports of the interrupt output stage.
   assumes binding into irq_output_config_holdoff, one clock. */
`timescale 1ns/1ps
module irq_out_checker
#(
    parameter int unsigned NUM_SRC = 32,
    parameter int unsigned POWER_SRC = 17
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic [7:0] stat_addr,
    input wire logic stat_wr,
    input wire logic [NUM_SRC-1:0] source_set,
    input wire logic [NUM_SRC-1:0] source_enable,
    input wire logic [NUM_SRC-1:0] source_status_flags,
    input wire logic irq_out,
    input wire logic irq_oe
);
    logic [7:0] s_int;
    logic s_en, s_pol, s_type, lvl, asrt, cfg_rd;
    // shadow of the config; lvl lags one cycle like the pin register
    always_ff @(posedge mclk)
        if (!resetn)
            {s_int, s_en, s_pol, s_type, lvl} <= '0;
        else if (reg_wr && reg_addr == 8'h54)
            {s_int, s_en, s_pol, s_type, lvl} <= {reg_wdata[31:24],
                reg_wdata[8], reg_wdata[4], reg_wdata[0], s_type & s_pol};
        else
            lvl <= s_type & s_pol;
    assign asrt = irq_oe && irq_out == lvl;
    assign cfg_rd = reg_rd && reg_addr == 8'h54;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_ack_clears: assert property (stat_wr && stat_addr == 8'h58 &&
        source_set == '0 |=> (source_status_flags &
        $past(reg_wdata[NUM_SRC-1:0])) == '0) else $error("ack no clear");
    a_fixed_bits: assert property (cfg_rd |=> reg_rdata[23:14] == '0 &&
        reg_rdata[11:9] == '0 && reg_rdata[7:5] == '0 &&
        reg_rdata[3:1] == '0) else $error("fixed bits set");
    a_req_bit: assert property (cfg_rd |=> reg_rdata[12] ==
        |$past(source_status_flags & source_enable)) else $error("req bit");
    a_cfg_back: assert property (cfg_rd |=> {reg_rdata[31:24],
        reg_rdata[8], reg_rdata[4], reg_rdata[0]} ==
        $past({s_int, s_en, s_pol, s_type})) else $error("cfg readback");
    a_pin_off: assert property (!$past(s_en) |-> !asrt)
        else $error("pin while off");
    a_od_low: assert property (!$past(s_type) && irq_oe |-> !irq_out)
        else $error("od high");
    a_pp_drive: assert property ($past(s_type) |-> irq_oe)
        else $error("pp undriven");
    a_power_now: assert property ($past(s_en &&
        source_status_flags[POWER_SRC] && source_enable[POWER_SRC])
        |-> asrt) else $error("power late");
    a_zero_free: assert property ($past(s_en && s_int == 8'h00 &&
        |(source_status_flags & source_enable)) |-> asrt)
        else $error("held at zero");
    c_held: cover property (cfg_rd ##1 reg_rdata[13]);
    c_power: cover property (asrt && source_status_flags[POWER_SRC]);
    c_ack: cover property (stat_wr && stat_addr == 8'h58);
endmodule
bind irq_output_config_holdoff irq_out_checker #(.NUM_SRC(NUM_SRC),
    .POWER_SRC(POWER_SRC)) chk_i (.mclk(mclk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .stat_addr(stat_addr),
    .stat_wr(stat_wr), .source_set(source_set),
    .source_enable(source_enable), .source_status_flags(source_status_flags),
    .irq_out(irq_out), .irq_oe(irq_oe));

// ---- bench/tb.sv ----
/* self-checking bench for the interrupt output stage.
   assumes a 4-cycle hold-off unit and a pulled-up pin. */
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic stat_wr = 1'b0, host_hi = 1'b0, irq_out, irq_oe, seen;
    logic [7:0] reg_addr = 8'h00, stat_addr = 8'h00;
    logic [31:0] reg_wdata = '0, source_set = '0, reg_rdata, flags, d;
    logic [31:0] source_enable = 32'h0002_0008;
    int n_errors = 0, n_tests = 0, cyc = 0;
    always #10 mclk = ~mclk;
    irq_output_config_holdoff #(.UNIT_CYCLES(4)) uut (.mclk(mclk),
        .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .stat_addr(stat_addr), .stat_wr(stat_wr), .source_set(source_set),
        .source_enable(source_enable), .source_status_flags(flags),
        .irq_out(irq_out), .irq_oe(irq_oe));
    irq_host_input host (.irq_out(irq_out), .irq_oe(irq_oe),
        .active_high(host_hi), .irq_seen(seen));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] cw(input logic [7:0] iv,
        input logic r, e, p, t);
        return {iv, 9'h0, r, 5'h0, e, 3'h0, p, 3'h0, t};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask
    // status ack shares the write data lines
    task automatic ack(input logic [31:0] m);
        @(posedge mclk);
        {stat_wr, stat_addr, reg_wdata} <= {1'b1, 8'h58, m};
        @(posedge mclk);
        stat_wr <= 1'b0;
    endtask
    task automatic pulse(input int k);
        @(posedge mclk);
        source_set <= 32'h1 << k;
        @(posedge mclk);
        source_set <= '0;
    endtask
    // bounded wait, then judge the level seen by the host
    task automatic waitv(input logic v, input int lim);
        for (int i = 0; i < lim && seen !== v; i++)
            @(negedge mclk);
        chk(seen, v);
    endtask
    task automatic t_regs();
        rd(8'h54);
        chk(d, 32'h0);
        wr(8'h54, cw(8'ha5, 1'b0, 1'b1, 1'b1, 1'b1));
        rd(8'h54);
        chk(d, cw(8'ha5, 1'b0, 1'b1, 1'b1, 1'b1));
        // a disabled source sets its flag but not the combined request
        pulse(5);
        rd(8'h54);
        chk(d[12], 1'b0);
        chk(flags[5], 1'b1);
        ack(32'h20);
        @(negedge mclk);
        chk(flags[5], 1'b0);
        rd(8'h60);
        chk(d, 32'h0);
        $display("t_regs done");
    endtask
    // every enable, polarity and buffer type with a live request
    task automatic t_pins();
        logic [2:0] c;
        pulse(3);
        for (int i = 0; i < 8; i++)
        begin
            c = 3'(i);
            host_hi <= c[0] & c[1];
            wr(8'h54, cw(8'h00, 1'b0, c[2], c[1], c[0]));
            repeat (2) @(negedge mclk);
            chk(seen, c[2]);
            chk({irq_oe, irq_out}, c[0] ? {1'b1, ~(c[2] ^ c[1])} :
                {c[2], 1'b0});
            rd(8'h54);
            chk(d[12], 1'b1);
        end
        ack(32'h8);
        $display("t_pins done");
    endtask
    task automatic t_holdoff();
        host_hi <= 1'b1;
        wr(8'h54, cw(8'h02, 1'b0, 1'b1, 1'b1, 1'b1));
        pulse(3);
        waitv(1'b1, 4);
        ack(32'h8);
        pulse(3);
        repeat (2) @(negedge mclk);
        chk(seen, 1'b0);
        rd(8'h54);
        chk(d[13:12], 2'b11);
        waitv(1'b1, 12);
        ack(32'h8);
        pulse(17);
        waitv(1'b1, 3);
        ack(32'h0002_0000);
        pulse(3);
        repeat (2) @(negedge mclk);
        chk(seen, 1'b0);
        wr(8'h54, cw(8'h00, 1'b0, 1'b1, 1'b1, 1'b1));
        waitv(1'b1, 2);
        ack(32'h8);
        $display("t_holdoff done");
    endtask
    task automatic t_restart();
        wr(8'h54, cw(8'h03, 1'b1, 1'b1, 1'b1, 1'b1));
        rd(8'h54);
        chk(d[14:13], 2'b01);
        pulse(3);
        repeat (2) @(negedge mclk);
        chk(seen, 1'b0);
        waitv(1'b1, 16);
        ack(32'h8);
        $display("t_restart done");
    endtask
    task automatic give_verdict();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard, far above the under two hundred cycles the tests need
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        t_regs();
        t_pins();
        t_holdoff();
        t_restart();
        give_verdict();
    end
endmodule
